//--- include/rpcf_consts.vh
// What this block does
// R1 - Set reset-done flag when 10 ms reset ends
// R2 - Writing 1 clears a flag, 0 leaves it
// R3 - Set overcurrent-change flag on indicator change
// R4 - Set resume-done flag after full resume sequence
// R5 - Reset-done flag setting clears resume-done flag
// R6 - Only hardware enable clearing sets enable-change
// R7 - Connect or disconnect event sets connect-change
// R8 - Command while disconnected sets connect-change
// R9 - Driver write effects wait for transaction end
// R10 - Driver writes zero to reserved bits
// R11 - Each port keeps its own flags
`ifndef RPCF_CONSTS_VH
`define RPCF_CONSTS_VH

// Register indices; the byte address is four times the index.
`define RPCF_RD_IDX_P1 8'h15
`define RPCF_RD_IDX_P2 8'h16
`define RPCF_WR_IDX_P1 8'h95
`define RPCF_WR_IDX_P2 8'h96

// Field positions in the port register.
`define RPCF_BIT_CONNECTED 0
`define RPCF_BIT_ENABLED 1
`define RPCF_BIT_SUSPEND_CMD 2
`define RPCF_BIT_OVERCURRENT 3
`define RPCF_BIT_RESET_CMD 4
`define RPCF_BIT_ENABLE_CMD 1
`define RPCF_FLAG_LO 16
`define RPCF_FLAG_HI 20
`define RPCF_BIT_CONNECT_CHG 16
`define RPCF_BIT_ENABLE_CHG 17
`define RPCF_BIT_RESUME_DONE 18
`define RPCF_BIT_OC_CHG 19
`define RPCF_BIT_RESET_DONE 20

// Reset values.
`define RPCF_FLAGS_RESET 5'h00
`define RPCF_WORD_RESET 32'h00000000

// Timing at the 100 MHz reference clock.
`define RPCF_CLK_KHZ 100000
`define RPCF_RESET_TIME_MS 10
`define RPCF_RESYNC_TIME_MS 3
// Cycle counts are written at the 20-bit timer width, so that no
// integer product is cut silently where it meets a parameter.
// Reset signalling: 10 ms times 100000 cycles per ms.
`define RPCF_RESET_CYCLES 20'hf4240
// Resync delay: 3 ms times 100000 cycles per ms.
`define RPCF_RESYNC_CYCLES 20'h493e0

`endif

//--- logic/rpcf_timer.v
`include "rpcf_consts.vh"

// One-shot interval timer: active for CYCLES cycles, then done for one.
module rpcf_timer #(
    parameter [19:0] CYCLES = 20'h00001
)
(
    input wire ref_clk,
    input wire reset,
    input wire start,
    input wire cancel,
    output reg active,
    output reg done
);

reg [19:0] count;

////////////////////////////////////////////////////////////////////////
// A start while running is ignored so the interval cannot stretch.
always @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        active <= 1'b0;
        done <= 1'b0;
        count <= 20'h00000;
    end
    else
    begin
        done <= 1'b0;
        if (cancel)
        begin
            active <= 1'b0;
            count <= 20'h00000;
        end
        else if (start && !active)
        begin
            active <= 1'b1;
            count <= 20'h00000;
        end
        else if (active)
        begin
            if (count == CYCLES - 20'h00001)
            begin
                active <= 1'b0;
                done <= 1'b1;
            end
            else
            begin
                count <= count + 20'h00001;
            end
        end
    end
end

endmodule

//--- logic/rpcf_top.v
// The register offsets and the APB slave port were chosen for this implementation.
`include "rpcf_consts.vh"

// Change-flag half of the two root port status registers, on APB.
module rpcf_top #(
    parameter [19:0] RESET_CYCLES = `RPCF_RESET_CYCLES,
    parameter [19:0] RESYNC_CYCLES = `RPCF_RESYNC_CYCLES
)
(
    input wire ref_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire txn_busy,
    input wire [1:0] port_connected,
    input wire [1:0] port_enabled,
    input wire [1:0] port_overcurrent,
    input wire [1:0] oc_change,
    input wire [1:0] resume_end,
    input wire [1:0] enable_hw_clear,
    input wire [1:0] connect_event,
    output wire [1:0] port_reset_cmd,
    output wire [1:0] port_enable_cmd,
    output wire [1:0] port_suspend_cmd,
    output wire [1:0] port_reset_drive,
    output wire [1:0] port_resync_active
);

// Flag positions inside the five-bit change field.
localparam FI_CONNECT = `RPCF_BIT_CONNECT_CHG - `RPCF_FLAG_LO;
localparam FI_ENABLE = `RPCF_BIT_ENABLE_CHG - `RPCF_FLAG_LO;
localparam FI_RESUME = `RPCF_BIT_RESUME_DONE - `RPCF_FLAG_LO;
localparam FI_OC = `RPCF_BIT_OC_CHG - `RPCF_FLAG_LO;
localparam FI_RESET = `RPCF_BIT_RESET_DONE - `RPCF_FLAG_LO;

// Byte addresses built from the register indices.
localparam [11:0] RD_ADDR_P1 = {2'b00, `RPCF_RD_IDX_P1, 2'b00};
localparam [11:0] RD_ADDR_P2 = {2'b00, `RPCF_RD_IDX_P2, 2'b00};
localparam [11:0] WR_ADDR_P1 = {2'b00, `RPCF_WR_IDX_P1, 2'b00};
localparam [11:0] WR_ADDR_P2 = {2'b00, `RPCF_WR_IDX_P2, 2'b00};

wire [63:0] status_word;
wire [1:0] pend_busy;
wire [1:0] rd_hit;
wire [1:0] wr_hit;
wire access;
wire done;
wire stall;

////////////////////////////////////////////////////////////////////////
// Address decode. Reads and writes use separate indices per port.
assign rd_hit[0] = !pwrite && (paddr == RD_ADDR_P1);
assign rd_hit[1] = !pwrite && (paddr == RD_ADDR_P2);
assign wr_hit[0] = pwrite && (paddr == WR_ADDR_P1);
assign wr_hit[1] = pwrite && (paddr == WR_ADDR_P2);
assign access = psel && penable && !pready;
assign done = psel && penable && pready;
// A second write to a port whose previous one still waits is held off.
assign stall = (wr_hit[0] && pend_busy[0]) || (wr_hit[1] && pend_busy[1]);

////////////////////////////////////////////////////////////////////////
// APB answer: pready rises one cycle into the access phase.
always @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `RPCF_WORD_RESET;
    end
    else if (pready)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `RPCF_WORD_RESET;
    end
    else if (access && !stall)
    begin
        pready <= 1'b1;
        if (rd_hit[0])
        begin
            prdata <= status_word[31:0];
            pslverr <= 1'b0;
        end
        else if (rd_hit[1])
        begin
            prdata <= status_word[63:32];
            pslverr <= 1'b0;
        end
        else if (wr_hit[0] || wr_hit[1])
        begin
            prdata <= `RPCF_WORD_RESET;
            pslverr <= 1'b0;
        end
        else
        begin
            // Unmapped address or wrong direction for the index.
            prdata <= `RPCF_WORD_RESET;
            pslverr <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Per-port logic; each copy has its own state and sees only its inputs.
genvar i;
generate
    for (i = 0; i < 2; i = i + 1)
    begin : port_blk // R11
        reg pend_valid;
        reg [31:0] pend_data;
        reg wr_apply;
        reg [31:0] wr_word;
        reg [4:0] flags;
        reg [4:0] next_flags;
        reg [4:0] clear_bits;
        reg [4:0] set_bits;
        reg reset_cmd;
        reg enable_cmd;
        reg suspend_cmd;
        wire cmd_any;
        wire cmd_ok;
        wire reset_start;
        wire reset_active;
        wire reset_done;
        wire resync_active;
        wire resync_done;

        assign pend_busy[i] = pend_valid || wr_apply;

        // The write is parked and applied only between transactions.
        always @(posedge ref_clk or posedge reset)
        begin
            if (reset)
            begin
                pend_valid <= 1'b0;
                pend_data <= `RPCF_WORD_RESET;
                wr_apply <= 1'b0;
                wr_word <= `RPCF_WORD_RESET;
            end
            else
            begin
                wr_apply <= pend_valid && !txn_busy; // R9
                if (pend_valid && !txn_busy)
                begin
                    wr_word <= pend_data;
                end
                if (done && wr_hit[i])
                begin
                    pend_valid <= 1'b1;
                    pend_data <= pwdata;
                end
                else if (!txn_busy)
                begin
                    pend_valid <= 1'b0; // R9
                end
            end
        end

        // Commands are refused while nothing is attached.
        assign cmd_any = wr_apply && (wr_word[`RPCF_BIT_RESET_CMD]
            || wr_word[`RPCF_BIT_ENABLE_CMD]
            || wr_word[`RPCF_BIT_SUSPEND_CMD]);
        assign cmd_ok = cmd_any && port_connected[i];
        assign reset_start = cmd_ok && wr_word[`RPCF_BIT_RESET_CMD];

        // Registered command pulses toward the port signalling logic.
        always @(posedge ref_clk or posedge reset)
        begin
            if (reset)
            begin
                reset_cmd <= 1'b0;
                enable_cmd <= 1'b0;
                suspend_cmd <= 1'b0;
            end
            else
            begin
                reset_cmd <= reset_start;
                enable_cmd <= cmd_ok && wr_word[`RPCF_BIT_ENABLE_CMD];
                suspend_cmd <= cmd_ok && wr_word[`RPCF_BIT_SUSPEND_CMD];
            end
        end

        // Times the reset signalling on the port.
        rpcf_timer #(
            .CYCLES(RESET_CYCLES)
        )
        reset_timer (
            .ref_clk(ref_clk),
            .reset(reset),
            .start(reset_start),
            .cancel(1'b0),
            .active(reset_active),
            .done(reset_done)
        );

        // Resync delay after the low-speed end of packet; a port reset
        // aborts it, since the resume no longer means anything.
        rpcf_timer #(
            .CYCLES(RESYNC_CYCLES)
        )
        resync_timer (
            .ref_clk(ref_clk),
            .reset(reset),
            .start(resume_end[i]),
            .cancel(reset_start || reset_active),
            .active(resync_active),
            .done(resync_done)
        );

        // Set terms win over a written clear in the same cycle; reset_done clearing the resume flag beats its set term.
        always @*
        begin
            clear_bits = 5'h00;
            set_bits = 5'h00;
            if (wr_apply)
            begin
                clear_bits = wr_word[`RPCF_FLAG_HI:`RPCF_FLAG_LO]; // R2
            end
            set_bits[FI_RESET] = reset_done; // R1
            set_bits[FI_OC] = oc_change[i]; // R3
            set_bits[FI_RESUME] = resync_done; // R4
            // Driver writes never reach this term.
            set_bits[FI_ENABLE] = enable_hw_clear[i]; // R6
            set_bits[FI_CONNECT] = connect_event[i] // R7
                || (cmd_any && !port_connected[i]); // R8
            next_flags = (flags & ~clear_bits) | set_bits;
            if (reset_done)
            begin
                next_flags[FI_RESUME] = 1'b0; // R5
            end
        end

        always @(posedge ref_clk or posedge reset)
        begin
            if (reset)
            begin
                flags <= `RPCF_FLAGS_RESET;
            end
            else
            begin
                flags <= next_flags;
            end
        end

        // Read view: change flags above, live port state below.
        assign status_word[i*32 +: 32] = {11'h000, flags, 11'h000,
            reset_active, port_overcurrent[i], 1'b0,
            port_enabled[i], port_connected[i]};
        assign port_reset_cmd[i] = reset_cmd;
        assign port_enable_cmd[i] = enable_cmd;
        assign port_suspend_cmd[i] = suspend_cmd;
        assign port_reset_drive[i] = reset_active;
        assign port_resync_active[i] = resync_active;
    end
endgenerate

endmodule

//--- tb/rpcf_props.sv
module rpcf_props (
    input logic ref_clk,
    input logic reset,
    input logic psel,
    input logic penable,
    input logic txn_busy,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [1:0] port_connected,
    input logic [1:0] port_reset_cmd,
    input logic [1:0] port_enable_cmd,
    input logic [1:0] port_suspend_cmd,
    input logic [1:0] port_reset_drive,
    input logic [1:0] port_resync_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [1:0] cmds;
    // Any command pulse, per port.
    assign cmds = port_reset_cmd | port_enable_cmd | port_suspend_cmd;
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    AST_ERR_ALONE: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside pready");
    AST_RESERVED_ZERO: assert property (pready |-> prdata[31:21] == 11'h0)
        else $error("reserved bits set");
    // The pulse leaves two edges after the edge that let the write in.
    AST_CMD_AFTER_TXN: assert property (|cmds |-> !$past(txn_busy, 2))
        else $error("command during transaction");
    AST_CMD_CONNECTED: assert property (
        (cmds & ~$past(port_connected)) == 2'h0)
        else $error("command at idle port");
    AST_DRIVE_LEN: assert property ($rose(port_reset_drive[0]) |->
        port_reset_drive[0] [*8] ##1 !port_reset_drive[0])
        else $error("reset drive length");
    AST_CMD_DRIVE: assert property (port_reset_cmd[0] |-> ##[0:1]
        port_reset_drive[0]) else $error("reset cmd without drive");
    // The count matches the short resync interval that the bench sets.
    AST_RESYNC_LEN: assert property ($rose(port_resync_active[0]) |->
        port_resync_active[0] [*5] ##1 !port_resync_active[0])
        else $error("resync length");
endmodule
bind rpcf_top rpcf_props chk (.ref_clk, .reset, .psel, .penable, .txn_busy,
    .prdata, .pready, .pslverr, .port_connected, .port_reset_cmd,
    .port_enable_cmd, .port_suspend_cmd, .port_reset_drive,
    .port_resync_active);

//--- tb/rpcf_top_tb.sv
module rpcf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, txn_busy;
    logic err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] attach, port_connected, connect_event, oc_change;
    logic [1:0] resume_end, enable_hw_clear, port_reset_drive;
    int miscompares = 0;
    int tests_run = 0;
    // Event kind and the flag bit it raises.
    int rows [4][2] = '{'{0, 19}, '{1, 17}, '{2, 16}, '{3, 18}};
    rpcf_top #(.RESET_CYCLES(20'h00008), .RESYNC_CYCLES(20'h00005)) dut (
        .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .txn_busy, .port_connected,
        .port_enabled(2'h0), .port_overcurrent(2'h0), .oc_change,
        .resume_end, .enable_hw_clear, .connect_event,
        .port_reset_cmd(), .port_enable_cmd(), .port_suspend_cmd(),
        .port_reset_drive, .port_resync_active());
    rpcf_usb_dev dev (.ref_clk, .attach, .port_connected, .connect_event);
    initial
    begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is sampled.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            finish_test();
        end
        // One idle edge, so that the next call never drives psel twice
        // in the same time step.
        @(posedge ref_clk);
    endtask
    task automatic rdchk(input int p, input logic [31:0] exp);
        apb(1'b0, 12'h054 + 12'(4 * p), 32'h0);
        check(rd & 32'h001f0000, exp);
    endtask
    task automatic pulse(input int k, input int p);
        case (k)
            0: oc_change[p] <= 1'b1;
            1: enable_hw_clear[p] <= 1'b1;
            2: attach[p] <= ~attach[p];
            3: resume_end[p] <= 1'b1;
        endcase
        @(posedge ref_clk);
        oc_change <= 2'h0;
        enable_hw_clear <= 2'h0;
        resume_end <= 2'h0;
        repeat (8) @(posedge ref_clk);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, txn_busy} = 0;
        {attach, oc_change, resume_end, enable_hw_clear} = 0;
        reset = 1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rdchk(0, 0);
        // Each event on each port, then clear by writing 0 and 1.
        for (int p = 0; p < 2; p++)
            for (int r = 0; r < 4; r++)
            begin
                pulse(rows[r][0], p);
                rdchk(p, 32'h1 << rows[r][1]);
                rdchk(1 - p, 0);
                apb(1'b1, 12'h254 + 12'(4 * p), 32'h0);
                rdchk(p, 32'h1 << rows[r][1]);
                apb(1'b1, 12'h254 + 12'(4 * p), 32'h1 << rows[r][1]);
                rdchk(p, 0);
            end
        apb(1'b0, 12'h100, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 12'h054, 32'h0);
        check({31'h0, err}, 32'h1);
        // Port 1 is unplugged; port 0 stays attached for the reset.
        pulse(2, 1);
        pulse(3, 0);
        // Only a reset command, so the resume flag can fall alone.
        apb(1'b1, 12'h254, 32'h00000010);
        repeat (14) @(posedge ref_clk);
        rdchk(0, 32'h00100000);
        // A clear written mid-transaction must wait for its end.
        txn_busy <= 1'b1;
        apb(1'b1, 12'h254, 32'h00100000);
        repeat (4) @(posedge ref_clk);
        rdchk(0, 32'h00100000);
        txn_busy <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdchk(0, 0);
        // Enable command at the unplugged port, with a clear of the
        // connect flag: the set from the refused command wins.
        apb(1'b1, 12'h258, 32'h00010002);
        rdchk(1, 32'h00010000);
        // A reset in mid-run drops every flag.
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rdchk(1, 0);
        finish_test();
    end
endmodule

//--- tb/rpcf_usb_dev.sv
module rpcf_usb_dev (
    input logic ref_clk,
    input logic [1:0] attach,
    output logic [1:0] port_connected = 2'h0,
    output logic [1:0] connect_event = 2'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Plugging is seen one edge late, with a single event pulse.
    always @(posedge ref_clk)
    begin
        connect_event <= attach ^ port_connected;
        port_connected <= attach;
    end
endmodule
